// ### isc_config_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Power-on clears every register to zero
// - Sequencer register at 0, 12 bits, default 0x100
// - Bit 0: double sampling or nondestructive readout
// - Double sampling: sample, reset row, sample, subtract
// - Variant bits 1-2 ignored unless nondestructive
// - Bit 3 resets pixels before readout
// - Bit 4: shutter or both-sides row addressing
// - Bits 5, 6: frame/line calibration fast or slow
// - Bit 7 selects continuous column precharge
// - Bits 8-9 form X sequencer granularity
// - Bit 10 disconnects column amplifiers, dark level
// - Bit 11 holds all pixels in reset
// - Register 1: 11-bit pixel count, max 1111
// - Register 2: 12-bit line count, max 3014
// - Register 4: valid and end pulse delays
// - Registers 5, 6: window start X, Y limits
// - Register 7: test mode, X/Y skip select
// - Register 8: gain, unity, one out, standby, delay
// - Registers 9-11: offset and dark DACs, default 0x80
// - Register 12: converter mux, switch, delay select
// - Register 12: standby, tristate, gamma, bit flip
// - Three-wire serial load places sequencer pulses
// - Variant codes: mode 1/2, reset or read
module isc_config_regs
	import isc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load,
	input wire logic preset_defaults,
	output isc_cfg_t cfg,
	output logic write_done
);

	// ==========================================================
	// Helpers
	function automatic logic [11:0] isc_fit(input logic [11:0] v,
		input logic [3:0] a);
		logic [11:0] m;
		m = v & ISC_WIDTH_MASK[a];
		isc_fit = (m > ISC_LIMIT[a]) ? ISC_LIMIT[a] : m;
	endfunction

	function automatic logic rising(input logic [2:0] s);
		rising = s[1] & ~s[2];
	endfunction

	isc_state_t state_reg;
	isc_state_t state_next;
	logic [3:0] wr_addr;
	logic [11:0] wr_data;
	logic [11:0] seq;
	logic [11:0] dly;
	logic [11:0] core;
	logic [11:0] amp;
	logic [11:0] adc;
	isc_cfg_t c;

	assign wr_addr = state_reg.shift[ISC_FRAME_BITS-1 -: ISC_ADDR_W];
	assign wr_data = state_reg.shift[ISC_DATA_W-1:0];

	// ==========================================================
	// Next state
	always_comb
	begin
		state_next = state_reg;
		state_next.write_done = 1'b0;
		// Stage 0 feeds only stage 1; edges look at stages 1 and 2
		state_next.clk_sync = {state_reg.clk_sync[1:0], ser_clk};
		state_next.data_sync = {state_reg.data_sync[0], ser_data};
		state_next.load_sync = {state_reg.load_sync[1:0], ser_load};

		// Shift address then data, MSB first, while load is low
		if (!state_reg.load_sync[1] && rising(state_reg.clk_sync))
		begin
			state_next.shift = {state_reg.shift[ISC_FRAME_BITS-2:0],
				state_reg.data_sync[1]};
			if (state_reg.count != 5'(ISC_FRAME_BITS))
				state_next.count = state_reg.count + 5'd1;
		end

		// Load edge commits a complete frame; short frames are dropped
		if (rising(state_reg.load_sync))
		begin
			state_next.count = 5'd0;
			if (state_reg.count == 5'(ISC_FRAME_BITS)
				&& wr_addr < 4'(ISC_NUM_REGS))
			begin
				state_next.regs[wr_addr] = isc_fit(wr_data, wr_addr);
				state_next.write_done = 1'b1;
			end
		end

		// Local preset of the documented defaults; power-on stays zero
		if (preset_defaults)
			state_next.regs = ISC_DEFAULT;

		// Decode current registers; outputs lag a write by one cycle
		seq = state_reg.regs[ISC_ADDR_SEQUENCER];
		dly = state_reg.regs[ISC_ADDR_PULSE_DELAY];
		core = state_reg.regs[ISC_ADDR_CORE_SUB];
		amp = state_reg.regs[ISC_ADDR_AMPLIFIER];
		adc = state_reg.regs[ISC_ADDR_CONVERTER];
		c = '0;

		c.nondestructive_select = seq[SEQ_NDR];
		c.double_sampling = ~seq[SEQ_NDR];
		// Variant forced to 00 in double sampling so it has no effect
		c.nondestructive_variant = seq[SEQ_NDR]
			? seq[SEQ_VARIANT_LO +: 2] : 2'b00;
		c.reset_before_read = seq[SEQ_RESET_BLACK];
		// Variant 1 also clocks both pointers identically
		c.both_sides = seq[SEQ_BOTH_SIDES]
			| (seq[SEQ_NDR] & ~seq[SEQ_VARIANT_LO + 1]);
		c.frame_cal_slow = seq[SEQ_FRAME_CAL];
		c.line_cal_slow = seq[SEQ_LINE_CAL];
		c.continuous_precharge = seq[SEQ_PRECHARGE];
		c.granularity = seq[SEQ_GRAN_LO +: 2];
		c.black = seq[SEQ_BLACK];
		c.reset_all = seq[SEQ_RESET_ALL];

		c.pixel_count = state_reg.regs[ISC_ADDR_PIXEL_COUNT][10:0];
		c.line_count = state_reg.regs[ISC_ADDR_LINE_COUNT];
		c.integration_time = state_reg.regs[ISC_ADDR_INTEGRATION];
		c.valid_pulse_delay = dly[DLY_VALID_LO +: 4];
		c.end_pulse_delay = dly[DLY_END_LO +: 4];
		c.x_start = state_reg.regs[ISC_ADDR_X_START][6:0];
		c.y_start = state_reg.regs[ISC_ADDR_Y_START][7:0];

		c.test_mode = core[CORE_TEST_LO +: 2];
		c.x_skip_select = core[CORE_XSKIP_LO +: 3];
		c.y_skip_select = core[CORE_YSKIP_LO +: 3];

		c.amp_gain = amp[AMP_GAIN_LO +: 4];
		c.amp_unity = amp[AMP_UNITY];
		c.amp_one_out = amp[AMP_ONE_OUT];
		c.amp_standby = amp[AMP_STANDBY];
		c.amp_clock_delay = amp[AMP_CLKDLY_LO +: 3];

		c.coarse_offset = state_reg.regs[ISC_ADDR_COARSE_DAC][7:0];
		c.fine_offset = state_reg.regs[ISC_ADDR_FINE_DAC][7:0];
		c.dark_level = state_reg.regs[ISC_ADDR_DARK_DAC][7:0];

		c.converter_standby = adc[ADC_STANDBY_LO +: 2];
		c.converter_mux_en = ~adc[ADC_ONE];
		c.converter_select = adc[ADC_ONE] & adc[ADC_SWITCH];
		c.out_delay_full = ~adc[ADC_ONE] & adc[ADC_SWITCH]
			& ~adc[ADC_CONVERTER_CLOCK_EXTERNAL];
		c.out_delay_half = ~adc[ADC_ONE] & adc[ADC_SWITCH]
			& adc[ADC_CONVERTER_CLOCK_EXTERNAL];
		c.converter_clock_external = adc[ADC_CONVERTER_CLOCK_EXTERNAL];
		c.out_tristate = adc[ADC_TRISTATE];
		c.converter_clock_delay = adc[ADC_CLKDLY_LO +: 3];
		c.gamma_law = adc[ADC_GAMMA];
		c.output_bit_flip = adc[ADC_FLIP];

		state_next.cfg = c;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg.clk_sync <= '0;
			state_reg.data_sync <= '0;
			// Idle high, so leaving reset shows no false load edge
			state_reg.load_sync <= '1;
			state_reg.shift <= '0;
			state_reg.count <= '0;
			state_reg.regs <= {ISC_NUM_REGS{ISC_POWER_ON}};
			state_reg.cfg <= '0;
			state_reg.write_done <= 1'b0;
		end
		else
			state_reg <= state_next;
	end

	assign cfg = state_reg.cfg;
	assign write_done = state_reg.write_done;

endmodule

// ### isc_config_regs_sva.sv
`timescale 1ns/1ps
module isc_config_regs_sva
	import isc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ser_load,
	input wire logic preset_defaults,
	input isc_cfg_t cfg,
	input wire logic write_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_defaults;
		cfg.pixel_count == 11'h200 && cfg.line_count == 12'hbc6 && cfg.dark_level == 8'h80;
	endsequence
	a_reset_clear: assert property ($rose(rst_n) |-> cfg == '0)
		else $error("config not cleared by reset");
	a_preset_load: assert property (preset_defaults |-> ##2 s_defaults)
		else $error("defaults not loaded");
	a_ds_inverse: assert property ($past(rst_n) |->
		cfg.double_sampling == !cfg.nondestructive_select)
		else $error("readout type decode wrong");
	a_variant_ignored: assert property (!cfg.nondestructive_select |->
		cfg.nondestructive_variant == 2'h0)
		else $error("variant seen in double sampling");
	a_pixel_limit: assert property (cfg.pixel_count <= 11'h457)
		else $error("pixel count above maximum");
	a_line_limit: assert property (cfg.line_count <= 12'hbc6)
		else $error("line count above maximum");
	a_window_limit: assert property (cfg.x_start <= 7'h62 && cfg.y_start <= 8'h89)
		else $error("window start out of range");
	a_conv_exclusive: assert property (cfg.converter_mux_en |->
		!cfg.converter_select && !(cfg.out_delay_full && cfg.out_delay_half))
		else $error("converter decode conflict");
	a_delay_select: assert property ((cfg.out_delay_full || cfg.out_delay_half) |->
		cfg.converter_mux_en && (cfg.out_delay_half == cfg.converter_clock_external))
		else $error("output delay not matched to clock source");
	a_done_pulse: assert property (write_done |=> !write_done)
		else $error("write done longer than a cycle");
	a_done_after_load: assert property (write_done |->
		$past(ser_load, 2) && !$past(ser_load, 7))
		else $error("write done without load edge");
endmodule
bind isc_config_regs isc_config_regs_sva i_sva (.clk(clk), .rst_n(rst_n), .ser_load(ser_load),
	.preset_defaults(preset_defaults), .cfg(cfg), .write_done(write_done));

// ### isc_ctl_model.sv
`timescale 1ns/1ps
// ========
// Camera controller side of the serial load link
module isc_ctl_model (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_load
);
	initial
	begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_load = 1'b1;
	end
	// Link clock stands low between frames; data flips once released
	task automatic send(input logic [3:0] a, input logic [11:0] d);
		logic [15:0] f;
		f = {a, d};
		repeat (4) @(posedge clk);
		#1 ser_load = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			repeat (4) @(posedge clk);
			#1 ser_data = f[i];
			repeat (4) @(posedge clk);
			#1 ser_clk = 1'b1;
			repeat (4) @(posedge clk);
			#1 ser_clk = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 ser_load = 1'b1;
		ser_data = ~ser_data;
	endtask
endmodule

// ### isc_pkg.sv
package isc_pkg;

	// ==========================================================
	// Register map
	localparam int ISC_NUM_REGS = 13;
	localparam int ISC_ADDR_W = 4;
	localparam int ISC_DATA_W = 12;
	localparam int ISC_FRAME_BITS = ISC_ADDR_W + ISC_DATA_W;

	localparam logic [3:0] ISC_ADDR_SEQUENCER = 4'h0;
	localparam logic [3:0] ISC_ADDR_PIXEL_COUNT = 4'h1;
	localparam logic [3:0] ISC_ADDR_LINE_COUNT = 4'h2;
	localparam logic [3:0] ISC_ADDR_INTEGRATION = 4'h3;
	localparam logic [3:0] ISC_ADDR_PULSE_DELAY = 4'h4;
	localparam logic [3:0] ISC_ADDR_X_START = 4'h5;
	localparam logic [3:0] ISC_ADDR_Y_START = 4'h6;
	localparam logic [3:0] ISC_ADDR_CORE_SUB = 4'h7;
	localparam logic [3:0] ISC_ADDR_AMPLIFIER = 4'h8;
	localparam logic [3:0] ISC_ADDR_COARSE_DAC = 4'h9;
	localparam logic [3:0] ISC_ADDR_FINE_DAC = 4'ha;
	localparam logic [3:0] ISC_ADDR_DARK_DAC = 4'hb;
	localparam logic [3:0] ISC_ADDR_CONVERTER = 4'hc;

	// Power-on value of every register
	localparam logic [11:0] ISC_POWER_ON = 12'h000;

	// Index 12 first, index 0 last
	localparam logic [12:0][11:0] ISC_WIDTH_MASK = {
		12'h7ff, 12'h0ff, 12'h0ff, 12'h0ff, 12'h3ff, 12'h0ff, 12'h0ff,
		12'h07f, 12'h0ff, 12'hfff, 12'hfff, 12'h7ff, 12'hfff};
	localparam logic [12:0][11:0] ISC_DEFAULT = {
		12'h000, 12'h080, 12'h080, 12'h080, 12'h010, 12'h000, 12'h000,
		12'h000, 12'h003, 12'h001, 12'hbc6, 12'h200, 12'h100};
	// Largest legal value; writes above it saturate
	localparam logic [12:0][11:0] ISC_LIMIT = {
		12'h7ff, 12'h0ff, 12'h0ff, 12'h0ff, 12'h3ff, 12'h0ff, 12'h089,
		12'h062, 12'h0ff, 12'hfff, 12'hbc6, 12'h457, 12'hfff};

	// ==========================================================
	// Field positions
	localparam int SEQ_NDR = 0;
	localparam int SEQ_VARIANT_LO = 1;
	localparam int SEQ_RESET_BLACK = 3;
	localparam int SEQ_BOTH_SIDES = 4;
	localparam int SEQ_FRAME_CAL = 5;
	localparam int SEQ_LINE_CAL = 6;
	localparam int SEQ_PRECHARGE = 7;
	localparam int SEQ_GRAN_LO = 8;
	localparam int SEQ_BLACK = 10;
	localparam int SEQ_RESET_ALL = 11;
	localparam int DLY_VALID_LO = 0;
	localparam int DLY_END_LO = 4;
	localparam int CORE_TEST_LO = 0;
	localparam int CORE_XSKIP_LO = 2;
	localparam int CORE_YSKIP_LO = 5;
	localparam int AMP_GAIN_LO = 0;
	localparam int AMP_UNITY = 4;
	localparam int AMP_ONE_OUT = 5;
	localparam int AMP_STANDBY = 6;
	localparam int AMP_CLKDLY_LO = 7;
	localparam int ADC_STANDBY_LO = 0;
	localparam int ADC_ONE = 2;
	localparam int ADC_SWITCH = 3;
	localparam int ADC_CONVERTER_CLOCK_EXTERNAL = 4;
	localparam int ADC_TRISTATE = 5;
	localparam int ADC_CLKDLY_LO = 6;
	localparam int ADC_GAMMA = 9;
	localparam int ADC_FLIP = 10;

	// ==========================================================
	// Decoded configuration seen by sequencer, counters, analog chain
	typedef struct packed {
		logic nondestructive_select;
		logic double_sampling;
		logic [1:0] nondestructive_variant;
		logic reset_before_read;
		logic both_sides;
		logic frame_cal_slow;
		logic line_cal_slow;
		logic continuous_precharge;
		logic [1:0] granularity;
		logic black;
		logic reset_all;
		logic [10:0] pixel_count;
		logic [11:0] line_count;
		logic [11:0] integration_time;
		logic [3:0] valid_pulse_delay;
		logic [3:0] end_pulse_delay;
		logic [6:0] x_start;
		logic [7:0] y_start;
		logic [1:0] test_mode;
		logic [2:0] x_skip_select;
		logic [2:0] y_skip_select;
		logic [3:0] amp_gain;
		logic amp_unity;
		logic amp_one_out;
		logic amp_standby;
		logic [2:0] amp_clock_delay;
		logic [7:0] coarse_offset;
		logic [7:0] fine_offset;
		logic [7:0] dark_level;
		logic [1:0] converter_standby;
		logic converter_mux_en;
		logic converter_select;
		logic out_delay_full;
		logic out_delay_half;
		logic converter_clock_external;
		logic out_tristate;
		logic [2:0] converter_clock_delay;
		logic gamma_law;
		logic output_bit_flip;
	} isc_cfg_t;

	typedef struct packed {
		logic [2:0] clk_sync;
		logic [1:0] data_sync;
		logic [2:0] load_sync;
		logic [15:0] shift;
		logic [4:0] count;
		logic [12:0][11:0] regs;
		isc_cfg_t cfg;
		logic write_done;
	} isc_state_t;

endpackage

// ### tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb import isc_pkg::*; ;
	logic clk, rst_n, preset_defaults, ser_clk, ser_data, ser_load, write_done;
	isc_cfg_t cfg;
	logic [11:0] m [13];
	logic [3:0] a;
	logic [3:0] cg;
	logic [3:0] cv;
	int fails = 0;
	int checked = 0;
	isc_config_regs i_dut (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_load(ser_load), .preset_defaults(preset_defaults), .cfg(cfg),
		.write_done(write_done));
	isc_ctl_model i_ctl (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ========
	// Register image rebuilt from the decoded outputs
	function automatic logic [11:0] get(int r);
		case (r)
			0: return {cfg.reset_all, cfg.black, cfg.granularity, cfg.continuous_precharge,
				cfg.line_cal_slow, cfg.frame_cal_slow, cfg.both_sides, cfg.reset_before_read,
				cfg.nondestructive_variant, cfg.nondestructive_select};
			1: return {1'b0, cfg.pixel_count};
			2: return cfg.line_count;
			3: return cfg.integration_time;
			4: return {4'h0, cfg.end_pulse_delay, cfg.valid_pulse_delay};
			5: return {5'h0, cfg.x_start};
			6: return {4'h0, cfg.y_start};
			7: return {4'h0, cfg.y_skip_select, cfg.x_skip_select, cfg.test_mode};
			8: return {2'h0, cfg.amp_clock_delay, cfg.amp_standby, cfg.amp_one_out,
				cfg.amp_unity, cfg.amp_gain};
			9: return {4'h0, cfg.coarse_offset};
			10: return {4'h0, cfg.fine_offset};
			11: return {4'h0, cfg.dark_level};
			default: return {1'b0, cfg.output_bit_flip, cfg.gamma_law, cfg.converter_clock_delay,
				cfg.out_tristate, cfg.converter_clock_external,
				cfg.out_delay_full | cfg.out_delay_half | cfg.converter_select,
				~cfg.converter_mux_en, cfg.converter_standby};
		endcase
	endfunction
	// Mode 1 drives rows from both sides as fast reset does
	function automatic logic [11:0] fix(int r, logic [11:0] v);
		if (r == 0)
		begin
			v[4] = v[4] | (v[0] & ~v[2]);
			if (!v[0])
				v[2:1] = 2'h0;
		end
		return v;
	endfunction
	task automatic chk_all;
		for (int r = 0; r < 13; r++)
			`CHK(get(r), fix(r, m[r]))
	endtask
	task automatic wr(input logic [3:0] ad, input logic [11:0] d);
		int n;
		logic [11:0] v;
		n = 0;
		i_ctl.send(ad, d);
		while (write_done !== 1'b1 && n < 12)
		begin
			@(posedge clk);
			#2 n++;
		end
		`CHK(n < 12, ad < 13)
		if (ad < 13)
		begin
			v = d & ISC_WIDTH_MASK[ad];
			m[ad] = (v > ISC_LIMIT[ad]) ? ISC_LIMIT[ad] : v;
		end
		@(posedge clk);
		#2 chk_all();
	endtask
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#400000;
		fails++;
		wrap_up();
	end
	initial
	begin
		void'($urandom(61));
		rst_n = 1'b0;
		preset_defaults = 1'b0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		foreach (m[i]) m[i] = '0;
		repeat (3) @(posedge clk);
		#1 chk_all();
		preset_defaults = 1'b1;
		@(posedge clk);
		#1 preset_defaults = 1'b0;
		foreach (m[i]) m[i] = ISC_DEFAULT[i];
		repeat (2) @(posedge clk);
		#1 chk_all();
		wr(4'h1, 12'h7ff);
		wr(4'h2, 12'hfff);
		wr(4'h5, 12'h07f);
		wr(4'h6, 12'h0ff);
		for (int i = 0; i < 8; i++)
			wr(4'h0, 12'(i));
		// Decoded converter controls checked one by one, not folded back
		for (int i = 0; i < 8; i++)
		begin
			wr(4'hc, 12'(i << 2));
			cg = {cfg.converter_mux_en, cfg.converter_select, cfg.out_delay_full,
				cfg.out_delay_half};
			cv = {~i[0], i[0] & i[1], ~i[0] & i[1] & ~i[2], ~i[0] & i[1] & i[2]};
			`CHK(cg, cv)
		end
		wr(4'hd, 12'hfff);
		for (int k = 0; k < 40; k++)
		begin
			a = 4'($urandom % 13);
			wr(a, 12'($urandom) & ISC_WIDTH_MASK[a]);
		end
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		foreach (m[i]) m[i] = '0;
		repeat (3) @(posedge clk);
		#1 chk_all();
		wrap_up();
	end
endmodule
